// >>> dv/rbf_formatter_properties.sv
// Port checker for the output formatter, bound to its top module.
// Assumes CTRL changes only by APB writes at offset zero.
`timescale 1ns/100ps
`default_nettype none
module rbf_formatter_properties (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic s0_valid,
	input wire logic s0_ready,
	input wire logic [11:0] baseband_out_pair,
	input wire logic back_end_gain_control
);
	logic [13:0] ctl;
	wire logic [11:0] bb = baseband_out_pair;
	wire logic byt = ctl[6] && ctl[3:0] < 4'h2;
	always_ff @(posedge ref_clk or negedge arst_n)
		if (!arst_n)
			ctl <= 14'h0000;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			ctl <= pwdata[13:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	apb_answer_a:
		assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_pulse_a:
		assert property (pready |=> !pready) else $error("ready held too long");
	unmapped_err_a:
		assert property (psel && !penable && paddr != 8'h00 && paddr != 8'h04 |=> pslverr)
		else $error("no error on unmapped address");
	slot_taken_a:
		assert property (s0_valid && s0_ready |=> !s0_ready) else $error("ready after take");
	gain_bypass_a:
		assert property ($stable(ctl) && ctl[3:0] < 4'hC |->
			back_end_gain_control == (ctl[5] && !ctl[0])) else $error("gain output wrong");
	spare_low_a:
		assert property (byt && $stable(ctl) |-> !bb[3] && !(ctl[0] && bb[11]))
		else $error("unused byte pair driven");
	byte_fast_a:
		assert property (byt && ctl[9:8] == 2'h0 && $rose(bb[6]) |-> bb[7] ##1 !bb[6] && !bb[7]
			##1 !bb[6] && bb[7] ##1 !bb[6] && !bb[7]) else $error("fast clock off data");
	byte_slow_a:
		assert property (byt && ctl[9:8] == 2'h1 && $rose(bb[6]) |-> !bb[7] ##1 bb[6] && bb[7]
			##1 !bb[6] && bb[7] ##1 !bb[7]) else $error("half rate clock not centred");
	port0_pairs_a:
		assert property (ctl[6] && ctl[3:0] > 4'h1 && ctl[9:8] == 2'h0 && $rose(bb[2]) |-> bb[3]
			##1 !bb[2] && !bb[3] ##1 !bb[2] && bb[3]) else $error("port 0 pair order wrong");
	cover property (byt && $rose(bb[6]));
	cover property (pslverr);
	cover property (ctl[3:0] > 4'h1 && $rose(bb[2]));
endmodule // rbf_formatter_properties
bind rbf_formatter rbf_formatter_properties i_rbf_formatter_properties (.ref_clk, .arst_n,
	.paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .s0_valid, .s0_ready,
	.baseband_out_pair, .back_end_gain_control);
`default_nettype wire

// >>> dv/rbf_receiver.sv
// Receiving logic model for one formatter port.
// Assumes the bench picks lanes, marker and clock out of the pairs.
`timescale 1ns/100ps
`default_nettype none
module rbf_receiver (
	input wire logic ref_clk,
	input wire logic [8:0] lanes,
	input wire logic [3:0] width,
	input wire logic marker,
	input wire logic fwd_clk,
	output logic [35:0] frame,
	output logic done
);
	logic lc = 1'b0;
	logic [35:0] acc, nxt;
	int t = 0;
	always @(posedge ref_clk) begin
		done <= 1'b0;
		lc <= fwd_clk;
		if (fwd_clk !== lc) begin
			t = marker ? 0 : t + 1;
			nxt = marker ? 36'h000000000 : acc;
			for (int k = 0; k < width; k++)
				nxt[36 - width * (t + 1) + k] = lanes[k];
			acc <= nxt;
			if (t == ((width == 4'h9) ? 3 : 32 / width - 1)) begin
				frame <= nxt;
				done <= 1'b1;
			end
		end
	end
endmodule // rbf_receiver
`default_nettype wire

// >>> dv/tb_rbf_formatter.sv
// Self-checking bench: APB setup, one sample in each of five modes, frame compare.
// Assumes the pair map of each port width; APB wait states are tolerated.
`timescale 1ns/100ps
`default_nettype none
module tb_rbf_formatter;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er, bg, mk, ck, done;
	logic [2:0] sv = 3'h0, sr;
	logic [17:0] si[3] = '{default: 18'h00000}, sq[3] = '{default: 18'h00000};
	logic [17:0] vi = 18'h2D3C5;
	logic [3:0] se[3] = '{default: 4'h0}, md, lw;
	logic [11:0] bb;
	logic [8:0] lv;
	logic [35:0] frame;
	logic [31:0] cf[5] = '{32'h00000070, 32'h00000161, 32'h00000867, 32'h0000206A, 32'h00000064};
	int cp[5] = '{0, 0, 1, 2, 0};
	logic [31:0] cs[5] = '{32'h000006C9, 32'h00000E89, 32'h0000151B, 32'h00001FFF, 32'h00001EC9};
	int num_errors = 0, total_checks = 0, pt = 0, g, n;
	rbf_formatter i_rbf_formatter (.ref_clk, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .s0_valid(sv[0]), .s0_i(si[0]), .s0_q(sq[0]), .s0_exp(se[0]),
		.s0_ready(sr[0]), .s1_valid(sv[1]), .s1_i(si[1]), .s1_q(sq[1]), .s1_exp(se[1]),
		.s1_ready(sr[1]), .s2_valid(sv[2]), .s2_i(si[2]), .s2_q(sq[2]), .s2_exp(se[2]),
		.s2_ready(sr[2]), .baseband_out_pair(bb), .back_end_gain_control(bg));
	rbf_receiver i_rbf_receiver (.ref_clk, .lanes(lv), .width(lw), .marker(mk), .fwd_clk(ck),
		.frame, .done);
	initial forever #4 ref_clk = ~ref_clk;
	always @* begin
		g = (md < 4'h2) ? 1 : pt;
		mk = bb[4 * g + 2];
		ck = bb[4 * g + 3];
		lw = 4'h2;
		lv = {7'h00, bb[4 * pt + 1], bb[4 * pt]};
		if (md < 4'h2) begin
			lw = md[0] ? 4'h8 : 4'h9;
			lv = md[0] ? {1'b0, bb[10:8], bb[5:4], bb[2:0]} : {bb[11:8], bb[5:4], bb[2:0]};
		end else if (md[3:1] == 3'h1 || md[3:1] == 3'h3) begin
			lw = 4'h4;
			lv = pt ? {5'h00, bb[11:8]} : {5'h00, bb[5:4], bb[1:0]};
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input int p, input logic [17:0] i, q, input logic [3:0] e);
		@(posedge ref_clk);
		sv[p] <= 1'b1;
		si[p] <= i;
		sq[p] <= q;
		se[p] <= e;
		do @(posedge ref_clk); while (sr[p] !== 1'b1);
		sv[p] <= 1'b0;
	endtask
	task automatic chk(input logic [35:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		end_of_test;
	end
	initial begin
		md = 4'h0;
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h00000000);
		chk(rd, 36'h000000000);
		apb(1'b1, 8'h04, 32'h0000FFFF);
		apb(1'b0, 8'h00, 32'h00000000);
		chk({er, rd}, 36'h000000000);
		apb(1'b0, 8'h08, 32'h00000000);
		chk(er, 36'h000000001);
		$display("test regs done");
		for (int c = 0; c < 5; c++) begin
			md = cf[c][3:0];
			pt = cp[c];
			vi = vi + 18'h13579;
			apb(1'b1, 8'h00, 32'h00000000);
			apb(1'b1, 8'h00, cf[c]);
			apb(1'b0, 8'h00, 32'h00000000);
			chk(rd, cf[c]);
			chk(bg, cf[c][5] && !cf[c][0]);
			chk(sr, (md < 4'h6) ? 3'h1 : (md < 4'hA) ? 3'h3 : 3'h7);
			apb(1'b0, 8'h04, 32'h00000000);
			chk(rd, cs[c]);
			send(pt, vi, ~vi, vi[3:0]);
			n = 0;
			while (done !== 1'b1 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			chk(done, 36'h000000001);
			if (cf[c][0])
				chk(frame, {vi[13:0], ~vi[13:0], vi[3:0], 4'h0});
			else if (cf[c][4])
				chk(frame, {vi, ~vi});
			else
				chk(frame, {vi[15:0], ~vi[15:0], 4'h0});
			$display("test %0d mode %h done", c, md);
		end
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({bg, bb, sr}, 36'h000000000);
		arst_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h00000000);
		chk(rd, 36'h000000000);
		$display("test reset done");
		end_of_test;
	end
endmodule // tb_rbf_formatter
`default_nettype wire

// >>> hdl/rbf_consts.vh
// Constants for the receive baseband output formatter.
// Assumes inclusion by hdl/rbf_formatter.v only.
`ifndef RBF_CONSTS_VH
`define RBF_CONSTS_VH
// Register byte offsets
`define RBF_REG_CTRL 8'h00
`define RBF_REG_STATUS 8'h04
// Control fields
`define RBF_CTRL_MODE 3:0
`define RBF_CTRL_WIDE 4
`define RBF_CTRL_GAIN 5
`define RBF_CTRL_EN 6
`define RBF_CTRL_DDR0 9:8
`define RBF_CTRL_DDR1 11:10
`define RBF_CTRL_DDR2 13:12
`define RBF_CTRL_RESET 32'h00000000
// Formatter modes
`define RBF_SINGLE_RATE_BYTE_FIXED 4'h0
`define RBF_SINGLE_RATE_BYTE_FLOAT 4'h1
`define RBF_SINGLE_RATE_NIBBLE_FIXED 4'h2
`define RBF_SINGLE_RATE_NIBBLE_FLOAT 4'h3
`define RBF_SINGLE_RATE_SERIAL_FIXED 4'h4
`define RBF_SINGLE_RATE_SERIAL_FLOAT 4'h5
`define RBF_DUAL_RATE_NIBBLE_FIXED 4'h6
`define RBF_DUAL_RATE_NIBBLE_FLOAT 4'h7
`define RBF_DUAL_RATE_SERIAL_FIXED 4'h8
`define RBF_DUAL_RATE_SERIAL_FLOAT 4'h9
`define RBF_TRIPLE_RATE_SERIAL_FIXED 4'hA
`define RBF_TRIPLE_RATE_SERIAL_FLOAT 4'hB
// Lane groups
`define RBF_LANES_BYTE9 2'h0
`define RBF_LANES_BYTE8 2'h1
`define RBF_LANES_NIBBLE 2'h2
`define RBF_LANES_SERIAL 2'h3
// Sample formats
`define RBF_FMT_FIX16 2'h0
`define RBF_FMT_FIX18 2'h1
`define RBF_FMT_FLOAT 2'h2
// Forwarded clock modes
`define RBF_DDR_MODE0 2'h0
`define RBF_DDR_MODE1 2'h1
// Transfers (clock edges) per complex sample
`define RBF_EDGES_BYTE 5'h04
`define RBF_EDGES_NIBBLE 5'h08
`define RBF_EDGES_SERIAL 5'h10
// Slot length minus one per forwarded clock mode
`define RBF_SLOT_FULL 2'h0
`define RBF_SLOT_HALF 2'h1
`define RBF_SLOT_QUARTER 2'h3
// Slot cycle at which a centred clock toggles
`define RBF_MID_FIRST 2'h0
`define RBF_MID_QUARTER 2'h1
// Shifter bits moved per transfer
`define RBF_SHIFT_BYTE9 4'h9
`define RBF_SHIFT_BYTE8 4'h8
`define RBF_SHIFT_NIBBLE 4'h4
`define RBF_SHIFT_SERIAL 4'h2
`endif

// >>> hdl/rbf_formatter.v
// Receive baseband output formatter: APB registers, three sample ports,
// twelve double-data-rate output pairs with forwarded clock and frame marker.
// Assumes the formatter source clock is ref_clk and samples arrive on it.
//
// Operation
// - Byte, nibble and serial port widths of 9 (8 for float), 4 and 2 lanes
// - Up to three output ports run at once, each with own rate
// - Float component is a mantissa plus a 4-bit exponent
// - Fixed component is 16 or 18 bits, no gain word
// - Fastest setting: forwarded clock toggles together with data
// - Half and quarter rate: clock toggles mid data interval
// - Byte fixed: 18-bit samples, 9 lanes, clock and marker
// - Byte float: mantissa and exponent on 8 lanes, clock, marker
// - Nibble: 16-bit fixed or 14-bit mantissa plus exponent, 4 lanes
// - Serial: samples on 2 lanes plus clock and marker
// - Dual nibble: two ports, four lanes, clock and marker each
// - Dual serial: two ports, two lanes, clock and marker each
// - Triple serial: three serial ports use all twelve pairs
// - Byte pair map: data 0-2, spare, 3-4, marker, clock, 5-8
// - Nibble pair map: port 0 pairs 0-5, port 1 pairs 6-11
// - Serial: each group of four pairs is data, data, marker, clock
// - One sample takes 2, 4 or 8 clock periods by width
// - Independent streams: 1 byte, 2 nibble, 3 serial
// - All twelve pairs are outputs only
// - Float output bypasses back-end gain control
`timescale 1ns/100ps
`default_nettype none
`include "rbf_consts.vh"

module rbf_port (
	input wire ref_clk,
	input wire arst_n,
	input wire en,
	input wire [1:0] lanes,
	input wire [1:0] fmt,
	input wire [1:0] ddr,
	input wire in_valid,
	input wire [17:0] in_i,
	input wire [17:0] in_q,
	input wire [3:0] in_exp,
	output reg in_ready,
	output wire [8:0] lane_bits,
	output reg marker,
	output reg fwd_clk
);
	reg [35:0] sr;
	reg [35:0] hold;
	reg full;
	reg [4:0] rem;
	reg [1:0] cnt;
	reg [1:0] len_m1;
	reg [1:0] half_m1;
	reg [3:0] shamt;
	reg [4:0] edges;
	reg [35:0] frame;
	wire tick;
	wire cap;
	wire load;
	wire next_full;

	// Narrow ports use the top lanes; the low ones carry don't-care bits
	assign lane_bits = sr[35:27];
	assign tick = (cnt == len_m1);
	assign cap = in_valid & in_ready;
	assign load = tick & (rem <= 5'h01) & full;
	// Capture wins over the drain of the same cycle
	assign next_full = cap | (full & ~load);

	always @* begin
		case (ddr)
		`RBF_DDR_MODE0: begin
			len_m1 = `RBF_SLOT_FULL;
			half_m1 = `RBF_MID_FIRST;
		end
		`RBF_DDR_MODE1: begin
			len_m1 = `RBF_SLOT_HALF;
			half_m1 = `RBF_MID_FIRST;
		end
		default: begin
			len_m1 = `RBF_SLOT_QUARTER;
			half_m1 = `RBF_MID_QUARTER;
		end
		endcase
		case (lanes)
		`RBF_LANES_BYTE9: begin
			shamt = `RBF_SHIFT_BYTE9;
			edges = `RBF_EDGES_BYTE;
		end
		`RBF_LANES_BYTE8: begin
			shamt = `RBF_SHIFT_BYTE8;
			edges = `RBF_EDGES_BYTE;
		end
		`RBF_LANES_NIBBLE: begin
			shamt = `RBF_SHIFT_NIBBLE;
			edges = `RBF_EDGES_NIBBLE;
		end
		default: begin
			shamt = `RBF_SHIFT_SERIAL;
			edges = `RBF_EDGES_SERIAL;
		end
		endcase
		// In-phase first, left aligned
		case (fmt)
		`RBF_FMT_FIX18: frame = {in_i, in_q};
		`RBF_FMT_FLOAT: frame = {in_i[13:0], in_q[13:0], in_exp, 4'h0};
		default: frame = {in_i[15:0], in_q[15:0], 4'h0};
		endcase
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr <= 36'h000000000;
			hold <= 36'h000000000;
			full <= 1'b0;
			rem <= 5'h00;
			cnt <= 2'h0;
			marker <= 1'b0;
			fwd_clk <= 1'b0;
			in_ready <= 1'b0;
		end else if (!en) begin
			// Disable empties the slot, so a new mode starts on a clean frame
			sr <= 36'h000000000;
			full <= 1'b0;
			rem <= 5'h00;
			cnt <= 2'h0;
			marker <= 1'b0;
			fwd_clk <= 1'b0;
			in_ready <= 1'b0;
		end else begin
			// Slot counter runs while idle; a new sample waits for the slot end
			cnt <= tick ? 2'h0 : cnt + 2'h1;
			if (cap)
				hold <= frame;
			full <= next_full;
			in_ready <= ~next_full;
			if (tick) begin
				if (rem > 5'h01) begin
					sr <= sr << shamt;
					rem <= rem - 5'h01;
					marker <= 1'b0;
				end else if (full) begin
					sr <= hold;
					rem <= edges;
					marker <= 1'b1;
				end else begin
					sr <= 36'h000000000;
					rem <= 5'h00;
					marker <= 1'b0;
				end
			end
			// Even edge count per sample, so the clock parks low
			if (ddr == `RBF_DDR_MODE0) begin
				if (tick && (rem > 5'h01 || full))
					fwd_clk <= ~fwd_clk;
			end else if (cnt == half_m1 && rem != 5'h00) begin
				fwd_clk <= ~fwd_clk;
			end
		end
	end
endmodule // rbf_port

module rbf_formatter (
	input wire ref_clk,
	input wire arst_n,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire s0_valid,
	input wire [17:0] s0_i,
	input wire [17:0] s0_q,
	input wire [3:0] s0_exp,
	output wire s0_ready,
	input wire s1_valid,
	input wire [17:0] s1_i,
	input wire [17:0] s1_q,
	input wire [3:0] s1_exp,
	output wire s1_ready,
	input wire s2_valid,
	input wire [17:0] s2_i,
	input wire [17:0] s2_q,
	input wire [3:0] s2_exp,
	output wire s2_ready,
	output reg [11:0] baseband_out_pair,
	output reg back_end_gain_control
);
	reg [31:0] ctrl;
	reg [1:0] lanes0;
	reg [1:0] lanes_n;
	reg [1:0] fmt;
	reg [1:0] nports;
	reg is_float;
	reg [11:0] next_pair;
	wire [3:0] mode;
	wire en;
	wire [2:0] port_en;
	wire [8:0] d0;
	wire [8:0] d1;
	wire [8:0] d2;
	wire [2:0] mark;
	wire [2:0] fclk;
	wire [7:0] l0;
	wire [7:0] ln;

	// Mode change while enabled is not guarded; software disables first
	assign mode = ctrl[`RBF_CTRL_MODE];
	assign en = ctrl[`RBF_CTRL_EN];
	// Ports beyond the stream count stay idle
	assign port_en = {en & (nports == 2'h3), en & (nports >= 2'h2), en};
	assign l0 = {6'h00, lanes0};
	assign ln = {6'h00, lanes_n};

	always @* begin
		is_float = mode[0];
		lanes_n = `RBF_LANES_SERIAL;
		case (mode)
		`RBF_SINGLE_RATE_BYTE_FIXED, `RBF_SINGLE_RATE_BYTE_FLOAT: begin
			lanes0 = is_float ? `RBF_LANES_BYTE8 : `RBF_LANES_BYTE9;
			nports = 2'h1;
		end
		`RBF_SINGLE_RATE_NIBBLE_FIXED, `RBF_SINGLE_RATE_NIBBLE_FLOAT: begin
			lanes0 = `RBF_LANES_NIBBLE;
			nports = 2'h1;
		end
		`RBF_DUAL_RATE_NIBBLE_FIXED, `RBF_DUAL_RATE_NIBBLE_FLOAT: begin
			lanes0 = `RBF_LANES_NIBBLE;
			lanes_n = `RBF_LANES_NIBBLE;
			nports = 2'h2;
		end
		`RBF_DUAL_RATE_SERIAL_FIXED, `RBF_DUAL_RATE_SERIAL_FLOAT: begin
			lanes0 = `RBF_LANES_SERIAL;
			nports = 2'h2;
		end
		`RBF_TRIPLE_RATE_SERIAL_FIXED, `RBF_TRIPLE_RATE_SERIAL_FLOAT: begin
			lanes0 = `RBF_LANES_SERIAL;
			nports = 2'h3;
		end
		default: begin
			lanes0 = `RBF_LANES_SERIAL;
			nports = 2'h1;
		end
		endcase
		// Wide fixed only fits the byte port
		if (is_float)
			fmt = `RBF_FMT_FLOAT;
		else if (ctrl[`RBF_CTRL_WIDE] && lanes0 == `RBF_LANES_BYTE9)
			fmt = `RBF_FMT_FIX18;
		else
			fmt = `RBF_FMT_FIX16;
	end

	// Ports 1 and 2 share one lane width; only port 0 can be byte wide
	rbf_port u_port0 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.en(port_en[0]),
		.lanes(lanes0),
		.fmt(fmt),
		.ddr(ctrl[`RBF_CTRL_DDR0]),
		.in_valid(s0_valid),
		.in_i(s0_i),
		.in_q(s0_q),
		.in_exp(s0_exp),
		.in_ready(s0_ready),
		.lane_bits(d0),
		.marker(mark[0]),
		.fwd_clk(fclk[0])
	);
	rbf_port u_port1 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.en(port_en[1]),
		.lanes(lanes_n),
		.fmt(fmt),
		.ddr(ctrl[`RBF_CTRL_DDR1]),
		.in_valid(s1_valid),
		.in_i(s1_i),
		.in_q(s1_q),
		.in_exp(s1_exp),
		.in_ready(s1_ready),
		.lane_bits(d1),
		.marker(mark[1]),
		.fwd_clk(fclk[1])
	);
	rbf_port u_port2 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.en(port_en[2]),
		.lanes(lanes_n),
		.fmt(fmt),
		.ddr(ctrl[`RBF_CTRL_DDR2]),
		.in_valid(s2_valid),
		.in_i(s2_i),
		.in_q(s2_q),
		.in_exp(s2_exp),
		.in_ready(s2_ready),
		.lane_bits(d2),
		.marker(mark[2]),
		.fwd_clk(fclk[2])
	);

	// Lane k of an L-lane port is lane_bits[9-L+k]; lowest lane carries the LSB
	always @* begin
		next_pair = 12'h000;
		if (lanes0 == `RBF_LANES_BYTE9 || lanes0 == `RBF_LANES_BYTE8) begin
			// Float leaves lane 8 idle, hence the shift by one
			if (lanes0 == `RBF_LANES_BYTE9)
				next_pair = {d0[8:5], fclk[0], mark[0], d0[4:3], 1'b0, d0[2:0]};
			else
				next_pair = {1'b0, d0[8:6], fclk[0], mark[0], d0[5:4], 1'b0, d0[3:1]};
		end else if (lanes0 == `RBF_LANES_NIBBLE) begin
			next_pair = {d1[8:5], fclk[1], mark[1], d0[8:7], fclk[0], mark[0], d0[6:5]};
		end else begin
			next_pair = {fclk[2], mark[2], d2[8:7], fclk[1], mark[1], d1[8:7],
				fclk[0], mark[0], d0[8:7]};
		end
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			baseband_out_pair <= 12'h000;
			back_end_gain_control <= 1'b0;
		end else begin
			baseband_out_pair <= next_pair;
			// Float samples carry their own exponent, so gain control stays off
			back_end_gain_control <= ctrl[`RBF_CTRL_GAIN] & ~is_float;
		end
	end

	// APB slave: answers in the first access cycle, never waits
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= `RBF_CTRL_RESET;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
				`RBF_REG_CTRL: begin
					prdata <= {18'h0, ctrl[13:0]};
				end
				`RBF_REG_STATUS: begin
					// Decoded configuration, for software sanity checks
					prdata <= {19'h0,
						l0[1:0],
						ln[1:0],
						nports,
						back_end_gain_control,
						port_en,
						s2_ready,
						s1_ready,
						s0_ready};
				end
				default: pslverr <= 1'b1;
				endcase
			end
			// Write lands only at the completing access edge
			if (psel && penable && pready && pwrite && paddr == `RBF_REG_CTRL)
				ctrl <= {18'h0, pwdata[13:0]};
		end
	end
endmodule // rbf_formatter
`default_nettype wire
